/* shared/xpd_pkg.sv */
// constants, types and window map for the extension-bus enable decoder
// Contract
// [RL1] first CAN enable low: block first CAN accesses, free its two port pins.
// [RL2] first CAN window goes external only when both CAN enables are low.
// [RL3] second CAN enable low: block second CAN accesses, free its two port pins.
// [RL4] second CAN window goes external only when both CAN enables are low.
// [RL5] small RAM enable low: window external, 2 KB RAM off; high: RAM serves.
// [RL6] large RAM enable low: window external, 8 KB RAM off; high: RAM serves.
// [RL7] clock enable low: clock blocked; window external only if both CANs off.
// [RL8] clock enable high: clock unit enabled and answers its window.
// [RL9] both CANs off: whole CAN window external, via matching address select.
// [RL10] reset value selects first CAN and small RAM only (0x0005).
// [RL11] enable register writes ignored once global peripheral enable is set.
// [RL12] emulation mode forces every enable bit set.
// [RL13] clock disabled: oscillator stops in power-down; else follows oscillator-off bit.
// [RL14] bits above the five enables read zero and ignore writes.
package xpd_pkg;

    // register byte addresses on apb
    localparam logic [15:0] XPD_ADDR_PERIPH_EN = 16'hF024;
    localparam logic [15:0] XPD_ADDR_SYS_CFG   = 16'hF028;
    localparam logic [15:0] XPD_ADDR_RTC_CTRL  = 16'hF02C;

    // enable register layout
    localparam int          XPD_EN_W          = 5;
    localparam logic [4:0]  XPD_EN_RESET      = 5'h05;
    localparam logic [4:0]  XPD_EN_ALL        = 5'h1F;
    localparam int          XPD_GPE_BIT       = 0;
    localparam int          XPD_RTC_OFF_BIT   = 0;
    localparam logic        XPD_GPE_RESET     = 1'h0;
    localparam logic        XPD_RTC_OFF_RESET = 1'h0;

    // address windows on the cpu side
    localparam int XPD_CPU_AW = 24;
    localparam int XPD_NWIN   = 6;
    localparam int XPD_W_CAN_A = 0;
    localparam int XPD_W_CAN_B = 1;
    localparam int XPD_W_SRAM  = 2;
    localparam int XPD_W_LRAM  = 3;
    localparam int XPD_W_RTC   = 4;
    localparam int XPD_W_CANS  = 5;
    localparam logic [23:0] XPD_WIN_LO [XPD_NWIN] = '{
        24'h00EF00, 24'h00EE00, 24'h00E000, 24'h00C000, 24'h00EC00, 24'h00EE00};
    localparam logic [23:0] XPD_WIN_HI [XPD_NWIN] = '{
        24'h00EFFF, 24'h00EEFF, 24'h00E7FF, 24'h00DFFF, 24'h00ECFF, 24'h00EFFF};

    // effective enables, bit order as in the register
    typedef struct packed {
        logic rtc;
        logic large_ram;
        logic small_ram;
        logic can_b;
        logic can_a;
    } xpd_en_t;

    // one-hot steering of a cpu access
    typedef struct packed {
        logic can_a;
        logic can_b;
        logic small_ram;
        logic large_ram;
        logic rtc;
        logic ext;
        logic blocked;
    } xpd_route_t;

    // software-visible control state
    typedef struct packed {
        logic [4:0] periph_en;
        logic       gpe;
        logic       rtc_off;
    } xpd_cfg_t;

endpackage

/* verilog/xpd_window_decode.sv */
// address window compare and steering of one cpu access
`timescale 1ns/1ps
module xpd_window_decode
    import xpd_pkg::*;
(
    input  wire logic [XPD_CPU_AW-1:0] addr,
    input  wire logic                  req,
    input  wire xpd_en_t               en,
    output xpd_route_t                 route
);

    logic [XPD_NWIN-1:0] hit;
    logic                cans_off;

    // one comparator pair per window
    genvar gi;
    generate
        for (gi = 0; gi < XPD_NWIN; gi++) begin : g_win
            assign hit[gi] = req && (addr >= XPD_WIN_LO[gi]) && (addr <= XPD_WIN_HI[gi]);
        end
    endgenerate

    assign cans_off = !en.can_a && !en.can_b;

    // steering; outside every window nothing is selected
    always_comb begin
        route = '0;
        if (hit[XPD_W_CAN_A]) begin
            route.can_a   = en.can_a;                     // [RL1]
            route.ext     = cans_off;                     // [RL2] [RL9]
            route.blocked = !en.can_a && !cans_off;       // [RL1]
        end else if (hit[XPD_W_CAN_B]) begin
            route.can_b   = en.can_b;                     // [RL3]
            route.ext     = cans_off;                     // [RL4] [RL9]
            route.blocked = !en.can_b && !cans_off;       // [RL3]
        end else if (hit[XPD_W_CANS]) begin
            // this window lies wholly inside the two can windows above, so this branch is never taken
            route.ext     = cans_off;                     // [RL9]
            route.blocked = !cans_off;
        end else if (hit[XPD_W_SRAM]) begin
            route.small_ram = en.small_ram;               // [RL5]
            route.ext       = !en.small_ram;              // [RL5]
        end else if (hit[XPD_W_LRAM]) begin
            route.large_ram = en.large_ram;               // [RL6]
            route.ext       = !en.large_ram;              // [RL6]
        end else if (hit[XPD_W_RTC]) begin
            route.rtc     = en.rtc;                       // [RL8]
            route.ext     = !en.rtc && cans_off;          // [RL7]
            route.blocked = !en.rtc && !cans_off;         // [RL7]
        end
    end

endmodule

/* verilog/xpd_xbus_peripheral_enable_decode.sv */
// extension-bus peripheral enable register, apb slave and access steering
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
module xpd_xbus_peripheral_enable_decode
    import xpd_pkg::*;
#(
    parameter int ADDR_W = 16
) (
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    // apb slave
    input  wire logic [ADDR_W-1:0]     paddr,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic                       pready,
    output logic [31:0]                prdata,
    output logic                       pslverr,
    // chip mode and power state
    input  wire logic                  emu_mode,
    input  wire logic                  pd_enter,
    // cpu access request
    input  wire logic                  cpu_req,
    input  wire logic [XPD_CPU_AW-1:0] cpu_addr,
    output xpd_route_t                 cpu_route,
    // unit enables and pin release
    output xpd_en_t                    unit_en,
    output logic                       can_a_pins_gpio,
    output logic                       can_b_pins_gpio,
    output logic                       rtc_osc_stop
);

    // whole module state in one struct
    typedef struct packed {
        xpd_cfg_t   cfg;
        logic [31:0] rdata;
        logic        slverr;
        xpd_route_t  route;
        xpd_en_t     en;
        logic        pins_a;
        logic        pins_b;
        logic        osc_stop;
    } xpd_top_state_t;

    xpd_top_state_t state_r;
    xpd_top_state_t state_nxt;

    // reset enables as a struct, so pin release at reset follows the same value
    localparam xpd_en_t EN_RST = xpd_en_t'(XPD_EN_RESET);

    logic       setup_ph;
    logic       access_ph;
    logic       hit_en;
    logic       hit_sys;
    logic       hit_rtc;
    logic       mapped;
    xpd_en_t    eff_en;
    xpd_route_t route_c;

    // apb phase decode; zero wait states, so access phase always completes
    assign setup_ph  = psel && !penable;
    assign access_ph = psel && penable;
    assign pready    = access_ph;
    assign pslverr   = access_ph && state_r.slverr;
    assign prdata    = state_r.rdata;

    // register decode on the full byte address
    assign hit_en  = (paddr[15:0] == XPD_ADDR_PERIPH_EN);
    assign hit_sys = (paddr[15:0] == XPD_ADDR_SYS_CFG);
    assign hit_rtc = (paddr[15:0] == XPD_ADDR_RTC_CTRL);
    assign mapped  = hit_en || hit_sys || hit_rtc;

    // emulation forces every unit on whatever software wrote
    always_comb begin
        if (emu_mode) begin
            eff_en = xpd_en_t'(XPD_EN_ALL);                // [RL12]
        end else begin
            eff_en = xpd_en_t'(state_r.cfg.periph_en);
        end
    end

    // window steering uses the live enables so a change acts on the next access
    xpd_window_decode u_decode (
        .addr  (cpu_addr),
        .req   (cpu_req),
        .en    (eff_en),
        .route (route_c)
    );

    // next-state logic: register writes, read capture, registered outputs
    always_comb begin
        state_nxt = state_r;

        // read data and error are fetched in setup, shown in access
        if (setup_ph) begin
            state_nxt.rdata  = '0;
            state_nxt.slverr = !mapped;
            if (hit_en) begin
                // upper bits stay zero on read
                state_nxt.rdata[XPD_EN_W-1:0] = state_r.cfg.periph_en;   // [RL14]
            end else if (hit_sys) begin
                state_nxt.rdata[XPD_GPE_BIT] = state_r.cfg.gpe;
            end else if (hit_rtc) begin
                state_nxt.rdata[XPD_RTC_OFF_BIT] = state_r.cfg.rtc_off;
            end
        end

        // writes land on the completing access edge, low byte lane only matters
        if (access_ph && pwrite && pstrb[0]) begin
            if (hit_en && !state_r.cfg.gpe) begin               // [RL11]
                // bits above the five enables are dropped
                state_nxt.cfg.periph_en = pwdata[XPD_EN_W-1:0];   // [RL14]
            end
            if (hit_sys) begin
                state_nxt.cfg.gpe = pwdata[XPD_GPE_BIT];
            end
            if (hit_rtc) begin
                state_nxt.cfg.rtc_off = pwdata[XPD_RTC_OFF_BIT];
            end
        end

        // steering and enables registered for clean outputs
        state_nxt.route  = route_c;
        state_nxt.en     = eff_en;                          // [RL5] [RL6] [RL8]
        state_nxt.pins_a = !eff_en.can_a;                   // [RL1]
        state_nxt.pins_b = !eff_en.can_b;                   // [RL3]

        // disabled clock unit always stops its oscillator in power-down
        if (!eff_en.rtc) begin
            state_nxt.osc_stop = pd_enter;                  // [RL13]
        end else begin
            state_nxt.osc_stop = pd_enter && state_r.cfg.rtc_off;   // [RL13]
        end
    end

    // state register, synchronous reset
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_r               <= '0;
            state_r.cfg.periph_en <= XPD_EN_RESET;           // [RL10]
            state_r.cfg.gpe       <= XPD_GPE_RESET;
            state_r.cfg.rtc_off   <= XPD_RTC_OFF_RESET;
            state_r.en            <= EN_RST;
            state_r.pins_a        <= !EN_RST.can_a;          // [RL1]
            state_r.pins_b        <= !EN_RST.can_b;          // [RL3]
        end else begin
            state_r <= state_nxt;
        end
    end

    // outputs straight from flip-flops
    assign cpu_route       = state_r.route;
    assign unit_en         = state_r.en;
    assign can_a_pins_gpio = state_r.pins_a;
    assign can_b_pins_gpio = state_r.pins_b;
    assign rtc_osc_stop    = state_r.osc_stop;

endmodule

/* dv/xpd_decode_checker.sv */
// port assertions for the extension-bus enable decoder
`timescale 1ns/1ps
module xpd_decode_checker
    import xpd_pkg::*;
#(
    parameter int ADDR_W = 16
) (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        emu_mode,
    input wire logic        pd_enter,
    input wire logic        cpu_req,
    input wire logic [23:0] cpu_addr,
    input wire xpd_route_t  cpu_route,
    input wire xpd_en_t     unit_en,
    input wire logic        can_a_pins_gpio,
    input wire logic        can_b_pins_gpio,
    input wire logic        rtc_osc_stop
);
    logic live_r;
    // outputs follow live inputs only from the first edge after reset
    always_ff @(posedge sys_clk) begin
        live_r <= !rst;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_hit(lo, hi);
        live_r && cpu_req && cpu_addr >= lo && cpu_addr <= hi;
    endsequence
    property p_rst;
        disable iff (1'b0) rst && !emu_mode |=> unit_en == XPD_EN_RESET;
    endproperty
    property p_pins;
        can_a_pins_gpio == !unit_en.can_a && can_b_pins_gpio == !unit_en.can_b;
    endproperty
    property p_emu;
        live_r && emu_mode |=> unit_en == XPD_EN_ALL;
    endproperty
    property p_can_a;
        s_hit(24'h00EF00, 24'h00EFFF) |=> cpu_route.can_a == unit_en.can_a
            && cpu_route.ext == !(unit_en.can_a || unit_en.can_b);
    endproperty
    property p_can_b;
        s_hit(24'h00EE00, 24'h00EEFF) |=> cpu_route.can_b == unit_en.can_b
            && cpu_route.ext == !(unit_en.can_a || unit_en.can_b);
    endproperty
    property p_sram;
        s_hit(24'h00E000, 24'h00E7FF) |=> cpu_route.small_ram == unit_en.small_ram
            && cpu_route.ext != unit_en.small_ram;
    endproperty
    property p_lram;
        s_hit(24'h00C000, 24'h00DFFF) |=> cpu_route.large_ram == unit_en.large_ram
            && cpu_route.ext != unit_en.large_ram;
    endproperty
    property p_rtc;
        s_hit(24'h00EC00, 24'h00ECFF) |=> cpu_route.rtc == unit_en.rtc
            && cpu_route.ext == !(unit_en.rtc || unit_en.can_a || unit_en.can_b);
    endproperty
    property p_osc_pd;
        live_r && pd_enter |=> unit_en.rtc || rtc_osc_stop;
    endproperty
    property p_osc_run;
        live_r && !pd_enter |=> !rtc_osc_stop;
    endproperty
    a_rst: assert property (p_rst) else $error("enable reset value wrong");
    a_pins: assert property (p_pins) else $error("pin release wrong");
    a_emu: assert property (p_emu) else $error("emulation not forcing");
    a_can_a: assert property (p_can_a) else $error("first can route");
    a_can_b: assert property (p_can_b) else $error("second can route");
    a_sram: assert property (p_sram) else $error("small ram route");
    a_lram: assert property (p_lram) else $error("large ram route");
    a_rtc: assert property (p_rtc) else $error("clock route");
    a_osc_pd: assert property (p_osc_pd) else $error("oscillator kept on");
    a_osc_run: assert property (p_osc_run) else $error("oscillator stopped");
endmodule
bind xpd_xbus_peripheral_enable_decode xpd_decode_checker #(.ADDR_W(ADDR_W)) u_chk (
    .sys_clk(sys_clk), .rst(rst), .emu_mode(emu_mode), .pd_enter(pd_enter),
    .cpu_req(cpu_req), .cpu_addr(cpu_addr), .cpu_route(cpu_route), .unit_en(unit_en),
    .can_a_pins_gpio(can_a_pins_gpio), .can_b_pins_gpio(can_b_pins_gpio),
    .rtc_osc_stop(rtc_osc_stop));

/* dv/xpd_cpu_model.sv */
// behavioural cpu core issuing single-cycle extension-bus accesses
`timescale 1ns/1ps
module xpd_cpu_model (
    input  wire logic  sys_clk,
    output logic       cpu_req,
    output logic [23:0] cpu_addr
);
    // idle until the first access
    initial begin
        cpu_req = 1'b0;
        cpu_addr = 24'h000000;
    end
    // address inverted after release so a stale sample cannot pass
    task automatic access(input logic [23:0] a);
        cpu_req <= 1'b1;
        cpu_addr <= a;
        @(posedge sys_clk);
        cpu_req <= 1'b0;
        cpu_addr <= ~a;
    endtask
endmodule

/* dv/tb_top.sv */
// self-checking bench for the extension-bus enable decoder
`timescale 1ns/1ps
module tb_top;
    import xpd_pkg::*;
    logic        sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic        emu_mode = 0, pd_enter = 0, pready, pslverr, cpu_req, ga, gb, stop, err;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [23:0] cpu_addr;
    xpd_route_t  cpu_route;
    xpd_en_t     unit_en;
    int          error_cnt = 0, comparisons = 0;
    // 40 MHz clock
    always #12.5 sys_clk = ~sys_clk;
    xpd_xbus_peripheral_enable_decode u_dut (.sys_clk(sys_clk), .rst(rst), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .emu_mode(emu_mode),
        .pd_enter(pd_enter), .cpu_req(cpu_req), .cpu_addr(cpu_addr), .cpu_route(cpu_route),
        .unit_en(unit_en), .can_a_pins_gpio(ga), .can_b_pins_gpio(gb), .rtc_osc_stop(stop));
    xpd_cpu_model u_cpu (.sys_clk(sys_clk), .cpu_req(cpu_req), .cpu_addr(cpu_addr));
    task automatic conclude;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    // one apb transfer, bounded wait on pready; an idle cycle follows
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            error_cnt++;
            conclude();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    // route shows one edge after the cpu sample
    task automatic rt(input logic [23:0] a, input logic [6:0] exp);
        u_cpu.access(a);
        #1 chk(32'(cpu_route), 32'(exp));
        @(posedge sys_clk);
    endtask
    // main sequence
    initial begin
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        apb(0, XPD_ADDR_PERIPH_EN, 0);
        chk(rd, 32'h5);
        chk(32'({unit_en, ga, gb}), 32'({XPD_EN_RESET, 2'b01}));
        rt(24'h00EF00, 7'h40);
        rt(24'h00EEFF, 7'h01);
        rt(24'h00E7FF, 7'h10);
        rt(24'h00C000, 7'h02);
        rt(24'h00EC00, 7'h01);
        rt(24'h00E800, 7'h00);
        apb(1, XPD_ADDR_PERIPH_EN, 32'hFFE0);
        apb(0, XPD_ADDR_PERIPH_EN, 0);
        chk(rd, 32'h0);
        chk(32'({ga, gb}), 32'h3);
        rt(24'h00EFFF, 7'h02);
        rt(24'h00EE00, 7'h02);
        rt(24'h00ECFF, 7'h02);
        rt(24'h00E000, 7'h02);
        apb(1, XPD_ADDR_PERIPH_EN, 32'h1A);
        rt(24'h00EC80, 7'h04);
        rt(24'h00DFFF, 7'h08);
        rt(24'h00EE80, 7'h20);
        rt(24'h00EF80, 7'h01);
        pd_enter <= 1'b1;
        apb(1, XPD_ADDR_RTC_CTRL, 32'h1);
        apb(0, XPD_ADDR_RTC_CTRL, 0);
        chk(32'({rd[0], stop}), 32'h3);
        apb(1, XPD_ADDR_RTC_CTRL, 32'h0);
        apb(0, XPD_ADDR_RTC_CTRL, 0);
        chk(32'(stop), 32'h0);
        apb(1, XPD_ADDR_PERIPH_EN, 32'h0);
        apb(0, XPD_ADDR_RTC_CTRL, 0);
        chk(32'(stop), 32'h1);
        pd_enter <= 1'b0;
        apb(1, XPD_ADDR_SYS_CFG, 32'h1);
        apb(1, XPD_ADDR_PERIPH_EN, 32'h1F);
        apb(0, XPD_ADDR_PERIPH_EN, 0);
        chk(rd, 32'h0);
        emu_mode <= 1'b1;
        rt(24'h00EF00, 7'h40);
        chk(32'(unit_en), 32'(XPD_EN_ALL));
        emu_mode <= 1'b0;
        apb(1, XPD_ADDR_SYS_CFG, 32'h0);
        apb(1, XPD_ADDR_PERIPH_EN, 32'h5);
        apb(0, XPD_ADDR_PERIPH_EN, 0);
        chk(rd, 32'h5);
        apb(0, 16'hF030, 0);
        chk(32'(err), 32'h1); // unmapped answers error
        chk(rd, 32'h0); // unmapped reads zero
        conclude();
    end
endmodule
